// ===== bench/cfs_core_model.sv
`timescale 1ns/100ps
module cfs_core_model
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_start,
   input wire logic core_wr_ready,
   output wire logic detect_busy,
   output wire logic cmd_done,
   output logic core_wr_valid,
   output wire logic [7:0] core_wr_data
);
   logic [4:0] det_q;
   logic [5:0] run_q;
   // detection after reset, command runs until wrap
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         det_q <= 5'h00;
         run_q <= 6'h00;
         core_wr_valid <= 1'b0;
      end
      else
      begin
         if (det_q != 5'h1F)
            det_q <= det_q + 5'h01;
         if (cmd_start)
            run_q <= 6'h01;
         else if (run_q != 6'h00)
            run_q <= run_q + 6'h01;
         // push held until taken
         if (run_q == 6'h03)
            core_wr_valid <= 1'b1;
         else if (core_wr_ready)
            core_wr_valid <= 1'b0;
      end
   end
   assign detect_busy = det_q < 5'h14;
   assign cmd_done = run_q >= 6'h0C;
   assign core_wr_data = core_wr_valid ? 8'hC3 : 8'h3C; // inverted when idle
endmodule // cfs_core_model

// ===== bench/cfs_regs_assertions.sv
`timescale 1ns/100ps
// apb and command checks
module cfs_regs_chk
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmd_done,
   input wire logic [2:0] tx_rx_machine_state,
   input wire logic [5:0] cmd_code,
   input wire logic cmd_start
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // access phase decode
   wire acc = psel && penable;
   wire rda = acc && !pwrite;
   wire [5:0] wcmd = pwdata[5:0];
   a_pready_high: assert property (pready) else $error("pready low");
   a_cmd_write: assert property (acc && pwrite && paddr == 8'h04 |=> cmd_start && cmd_code == $past(wcmd)) else $error("cmd write");
   a_start_single: assert property (cmd_start |=> !cmd_start) else $error("start long");
   a_cmd_readback: assert property (rda && paddr == 8'h04 |-> prdata[6:0] == {1'b0, cmd_code} && prdata[31:8] == 0) else $error("cmd read");
   a_stat_fields: assert property (rda && paddr == 8'h0C |-> prdata[7:4] == {1'b0, tx_rx_machine_state}) else $error("status");
   a_done_clears: assert property ($rose(cmd_done) && cmd_code != 0 |-> ##[1:4] (cmd_code == 0 || cmd_start)) else $error("done");
   a_unmapped_err: assert property (acc && paddr > 8'h1C |-> pslverr && prdata == 0) else $error("unmapped");
   a_idle_quiet: assert property (!acc |-> prdata == 0 && !pslverr) else $error("idle bus");
   a_reset_idle: assert property (@(posedge clk) disable iff (1'b0) !nrst |=> cmd_code == 0 && !cmd_start) else $error("reset");
   c_start: cover property (cmd_start);
   c_done: cover property ($rose(cmd_done));
   c_err: cover property (pslverr);
endmodule // cfs_regs_chk
bind cfs_regs cfs_regs_chk chk_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .cmd_done, .tx_rx_machine_state, .cmd_code, .cmd_start);

// ===== bench/tb.sv
`timescale 1ns/100ps
module tb;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic cmd_error = 0, core_irq = 0;
   logic [2:0] mstate = 3'h5;
   wire [31:0] prdata;
   wire pready, pslverr, irq, detect_busy, cmd_done, cmd_start, core_wr_valid, core_wr_ready;
   wire core_rd_valid;
   wire [5:0] cmd_code;
   wire [7:0] core_wr_data, core_rd_data;
   int n_fail = 0, num_checks = 0, cyc = 0;
   cfs_regs dut_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .detect_busy, .cmd_done, .cmd_error, .tx_rx_machine_state(mstate),
      .core_irq, .cmd_code, .cmd_start, .core_wr_valid, .core_wr_ready, .core_wr_data,
      .core_rd_valid, .core_rd_ready(1'b0), .core_rd_data);
   cfs_core_model core_u (.clk, .nrst, .cmd_start, .core_wr_ready, .detect_busy, .cmd_done,
      .core_wr_valid, .core_wr_data);
   always #2 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         end_sim;
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one apb transfer, request held through the ready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // access phase lasts until ready is seen at a rising edge
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(0, a, 0);
      chk(nm, rd, e);
   endtask
   // status is 0x01 plus machine state 5 in bits 6..4
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1;
      rdc(8'h04, 32'h80, "cmd reset");
      rdc(8'h0C, 32'h51, "status");
      apb(1, 8'h0C, 32'hFF);
      rdc(8'h0C, 32'h51, "status kept");
      rdc(8'h40, 32'h0, "unmapped");
      chk("slverr", err, 1);
      $display("test regs done");
      repeat (30) @(posedge clk);
      rdc(8'h04, 32'h00, "detect done");
      for (int i = 0; i < 3; i++)
         apb(1, 8'h08, 32'hA0 + i);
      for (int i = 0; i < 3; i++)
         rdc(8'h08, 32'hA0 + i, "fifo");
      $display("test fifo done");
      apb(1, 8'h04, 32'hEA);
      rdc(8'h04, 32'h2A, "cmd running");
      repeat (80) @(posedge clk);
      rdc(8'h04, 32'h00, "cmd finished");
      @(negedge clk);
      chk("irq masked", irq, 0);
      apb(1, 8'h14, 32'h1);
      @(negedge clk);
      chk("irq on", irq, 1);
      rdc(8'h10, 32'h1, "irq status");
      @(negedge clk);
      chk("irq cleared", irq, 0);
      @(negedge clk);
      chk("core rd head", {core_rd_valid, core_rd_data}, 9'h1C3);
      rdc(8'h08, 32'hC3, "core byte");
      $display("test command done");
      core_irq <= 1;
      cmd_error <= 1;
      mstate <= 3'h2;
      repeat (4) @(posedge clk);
      rdc(8'h0C, 32'h2D, "status flags");
      rdc(8'h10, 32'h8, "error event");
      apb(1, 8'h04, 32'h01);
      rdc(8'h0C, 32'h29, "error cleared");
      repeat (20) @(posedge clk);
      apb(1, 8'h1C, 32'h1);
      rdc(8'h0C, 32'h2A, "high alert");
      rdc(8'h10, 32'h3, "done and high");
      $display("test status done");
      end_sim;
   end
endmodule // tb

// ===== src/cfs_defs.vh
// Behaviour
// - bit 7 shows interface detection busy
// - writing command field starts that command
// - command field reads the running command
// - reset clears bits 6..0, bit 7 live
// - bit 6 reserved, reads zero, read-only
// - byte data port at 0x02 into FIFO
// - FIFO carries all host and tx/rx data
// - read-only status at 0x03, resets 0x01
// - command field self-updates when command finishes
// - read-only flags ignore host writes
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH
`define CFS_ADDR_W 8
`define CFS_IDX_CMD 6'h01
`define CFS_IDX_FIFO 6'h02
`define CFS_IDX_STAT 6'h03
`define CFS_OFF_CMD {`CFS_IDX_CMD, 2'b00}
`define CFS_OFF_FIFO {`CFS_IDX_FIFO, 2'b00}
`define CFS_OFF_STAT {`CFS_IDX_STAT, 2'b00}
`define CFS_OFF_IRQ_STAT 8'h10
`define CFS_OFF_IRQ_MASK 8'h14
`define CFS_OFF_FIFO_LVL 8'h18
`define CFS_OFF_THRESH 8'h1C
`define CFS_CMD_IDLE 6'h00
`define CFS_CMD_MSB 5
`define CFS_BIT_DETECT 7
`define CFS_STAT_RESET 8'h01
`define CFS_FIFO_DEPTH 64
`define CFS_FIFO_AW 6
`define CFS_LVL_W 7
`define CFS_FIFO_FULL 7'h40
`define CFS_THR_LO_LSB 8
`define CFS_HI_THR_RESET 7'h3C
`define CFS_LO_THR_RESET 7'h04
`define CFS_IRQ_W 4
`define CFS_IRQ_CMD_DONE 0
`define CFS_IRQ_HI 1
`define CFS_IRQ_LO 2
`define CFS_IRQ_ERR 3
`endif

// ===== src/cfs_fifo.v
`timescale 1ns/100ps
`include "cfs_defs.vh"
// 64 x 8 byte buffer with honest full and empty
module cfs_fifo
(
   input wire clk,
   input wire nrst,
   input wire wr_valid,
   output wire wr_ready,
   input wire [7:0] wr_data,
   output wire rd_valid,
   input wire rd_ready,
   output wire [7:0] rd_data,
   input wire flush,
   output wire [`CFS_LVL_W-1:0] level
);
   reg [7:0] mem [0:`CFS_FIFO_DEPTH-1];
   reg [`CFS_FIFO_AW-1:0] wp_q;
   reg [`CFS_FIFO_AW-1:0] rp_q;
   reg [`CFS_LVL_W-1:0] cnt_q;
   wire push;
   wire pop;

   // count is one bit wider than the pointers so a full buffer is visible
   assign wr_ready = (cnt_q != `CFS_FIFO_FULL);
   assign rd_valid = (cnt_q != {`CFS_LVL_W{1'b0}});
   assign push = wr_valid & wr_ready;
   assign pop = rd_valid & rd_ready;
   assign rd_data = mem[rp_q]; // oldest byte always at the head
   assign level = cnt_q;

   // storage has no reset; contents are don't-care until written
   always @(posedge clk)
   begin
      if (push)
         mem[wp_q] <= wr_data;
   end

   // pointers and count; flush drops everything
   always @(posedge clk)
   begin
      if (!nrst || flush)
      begin
         wp_q <= {`CFS_FIFO_AW{1'b0}};
         rp_q <= {`CFS_FIFO_AW{1'b0}};
         cnt_q <= {`CFS_LVL_W{1'b0}};
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // cfs_fifo

// ===== src/cfs_regs.v
`timescale 1ns/100ps
`include "cfs_defs.vh"
// command, fifo data port and primary status over apb
module cfs_regs
(
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`CFS_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire irq,
   input wire detect_busy,
   input wire cmd_done,
   input wire cmd_error,
   input wire [2:0] tx_rx_machine_state,
   input wire core_irq,
   output wire [5:0] cmd_code,
   output wire cmd_start,
   input wire core_wr_valid,
   output wire core_wr_ready,
   input wire [7:0] core_wr_data,
   output wire core_rd_valid,
   input wire core_rd_ready,
   output wire [7:0] core_rd_data
);
   reg detect_s1_q;
   reg detect_s2_q;
   reg done_s1_q;
   reg done_s2_q;
   reg done_s3_q;
   reg err_s1_q;
   reg err_s2_q;
   reg err_s3_q;
   reg irqin_s1_q;
   reg irqin_s2_q;
   reg [5:0] cmd_q;
   reg [5:0] cmd_d;
   reg start_q;
   reg err_q;
   reg [`CFS_IRQ_W-1:0] ists_q;
   reg [`CFS_IRQ_W-1:0] imask_q;
   reg [`CFS_LVL_W-1:0] hi_thr_q;
   reg [`CFS_LVL_W-1:0] lo_thr_q;
   reg hi_prev_q;
   reg lo_prev_q;
   reg [31:0] rdata_d;
   wire acc;
   wire wr_acc;
   wire rd_acc;
   wire host_push;
   wire host_pop;
   wire fifo_wr_valid;
   wire fifo_wr_ready;
   wire [7:0] fifo_wr_data;
   wire fifo_rd_valid;
   wire fifo_rd_ready;
   wire [7:0] fifo_rd_data;
   wire [`CFS_LVL_W-1:0] level;
   wire done_pulse;
   wire err_pulse;
   wire hi_flag;
   wire lo_flag;
   wire [7:0] stat_byte;
   wire [`CFS_IRQ_W-1:0] ev;
   wire flush;

   // address match used by both read and write decode
   function hit;
      input [`CFS_ADDR_W-1:0] a;
      input [`CFS_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // zero wait-state slave; every access finishes in its access phase
   assign pready = 1'b1;
   assign acc = psel & penable;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign pslverr = acc & ~(hit(paddr, `CFS_OFF_CMD) | hit(paddr, `CFS_OFF_FIFO)
      | hit(paddr, `CFS_OFF_STAT) | hit(paddr, `CFS_OFF_IRQ_STAT)
      | hit(paddr, `CFS_OFF_IRQ_MASK) | hit(paddr, `CFS_OFF_FIFO_LVL)
      | hit(paddr, `CFS_OFF_THRESH));

   // detect, done, error and irq pins from the core may be asynchronous: two flops before use
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         detect_s1_q <= 1'b1;
         detect_s2_q <= 1'b1;
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
         err_s1_q <= 1'b0;
         err_s2_q <= 1'b0;
         err_s3_q <= 1'b0;
         irqin_s1_q <= 1'b0;
         irqin_s2_q <= 1'b0;
      end
      else
      begin
         detect_s1_q <= detect_busy;
         detect_s2_q <= detect_s1_q;
         done_s1_q <= cmd_done;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
         err_s1_q <= cmd_error;
         err_s2_q <= err_s1_q;
         err_s3_q <= err_s2_q;
         irqin_s1_q <= core_irq;
         irqin_s2_q <= irqin_s1_q;
      end
   end

   // rising edges, taken from second stage onward only
   assign done_pulse = done_s2_q & ~done_s3_q;
   assign err_pulse = err_s2_q & ~err_s3_q;

   // host writes to the fifo port push; reads pop
   assign host_push = wr_acc & hit(paddr, `CFS_OFF_FIFO);
   assign host_pop = rd_acc & hit(paddr, `CFS_OFF_FIFO);

   // while idle the host alone writes the buffer, otherwise the core fills it too, with host writes taking priority
   assign fifo_wr_valid = host_push | (core_wr_valid & (cmd_q != `CFS_CMD_IDLE));
   assign fifo_wr_data = host_push ? pwdata[7:0] : core_wr_data;
   assign core_wr_ready = fifo_wr_ready & ~host_push & (cmd_q != `CFS_CMD_IDLE);
   assign fifo_rd_ready = host_pop | (core_rd_ready & ~host_pop);
   assign core_rd_valid = fifo_rd_valid & ~host_pop;
   assign core_rd_data = fifo_rd_data;
   // a write of the level register empties the buffer
   assign flush = wr_acc & hit(paddr, `CFS_OFF_FIFO_LVL);

   // the shared 64-byte buffer behind the data port
   cfs_fifo u_fifo
   (
      .clk(clk),
      .nrst(nrst),
      .wr_valid(fifo_wr_valid),
      .wr_ready(fifo_wr_ready),
      .wr_data(fifo_wr_data),
      .rd_valid(fifo_rd_valid),
      .rd_ready(fifo_rd_ready),
      .rd_data(fifo_rd_data),
      .flush(flush),
      .level(level)
   );

   // command field: host launches, core returns it to idle
   always @*
   begin
      cmd_d = cmd_q;
      if (done_pulse)
         cmd_d = `CFS_CMD_IDLE;
      if (wr_acc && hit(paddr, `CFS_OFF_CMD))
         cmd_d = pwdata[`CFS_CMD_MSB:0];
   end

   // command state, error flag and thresholds
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         cmd_q <= `CFS_CMD_IDLE;
         start_q <= 1'b0;
         err_q <= 1'b0;
         hi_thr_q <= `CFS_HI_THR_RESET;
         lo_thr_q <= `CFS_LO_THR_RESET;
      end
      else
      begin
         cmd_q <= cmd_d;
         start_q <= wr_acc & hit(paddr, `CFS_OFF_CMD);
         // error is raised by the core and cleared by a new launch
         if (err_pulse)
            err_q <= 1'b1;
         else if (wr_acc && hit(paddr, `CFS_OFF_CMD))
            err_q <= 1'b0;
         if (wr_acc && hit(paddr, `CFS_OFF_THRESH))
         begin
            hi_thr_q <= pwdata[`CFS_LVL_W-1:0];
            lo_thr_q <= pwdata[`CFS_THR_LO_LSB+`CFS_LVL_W-1:`CFS_THR_LO_LSB];
         end
      end
   end

   assign cmd_code = cmd_q;
   assign cmd_start = start_q;

   // fifo alert flags derived from live level
   assign hi_flag = (level >= hi_thr_q);
   assign lo_flag = (level <= lo_thr_q);
   // after reset: empty fifo so only the low alert shows, 0x01
   assign stat_byte = {1'b0, tx_rx_machine_state, irqin_s2_q, err_q, hi_flag, lo_flag};

   // interrupt events: command done, alert entries, error
   assign ev[`CFS_IRQ_CMD_DONE] = done_pulse;
   assign ev[`CFS_IRQ_HI] = hi_flag & ~hi_prev_q;
   assign ev[`CFS_IRQ_LO] = lo_flag & ~lo_prev_q;
   assign ev[`CFS_IRQ_ERR] = err_pulse;

   // sticky status, cleared by read; a same-cycle event wins
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         ists_q <= {`CFS_IRQ_W{1'b0}};
         imask_q <= {`CFS_IRQ_W{1'b0}};
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b1;
      end
      else
      begin
         hi_prev_q <= hi_flag;
         lo_prev_q <= lo_flag;
         if (rd_acc && hit(paddr, `CFS_OFF_IRQ_STAT))
            ists_q <= ev;
         else
            ists_q <= ists_q | ev;
         if (wr_acc && hit(paddr, `CFS_OFF_IRQ_MASK))
            imask_q <= pwdata[`CFS_IRQ_W-1:0];
      end
   end

   assign irq = |(ists_q & imask_q);

   // read mux; status and reserved bits have no write path
   always @*
   begin
      rdata_d = 32'h00000000;
      if (hit(paddr, `CFS_OFF_CMD))
         // live detect bit, reserved bit 6 zero, running command
         rdata_d[7:0] = {detect_s2_q, 1'b0, cmd_q};
      else if (hit(paddr, `CFS_OFF_FIFO))
         rdata_d[7:0] = fifo_rd_data; // empty fifo reads stale byte
      else if (hit(paddr, `CFS_OFF_STAT))
         rdata_d[7:0] = stat_byte;
      else if (hit(paddr, `CFS_OFF_IRQ_STAT))
         rdata_d[`CFS_IRQ_W-1:0] = ists_q;
      else if (hit(paddr, `CFS_OFF_IRQ_MASK))
         rdata_d[`CFS_IRQ_W-1:0] = imask_q;
      else if (hit(paddr, `CFS_OFF_FIFO_LVL))
         rdata_d[`CFS_LVL_W-1:0] = level;
      else if (hit(paddr, `CFS_OFF_THRESH))
         rdata_d[15:0] = {1'b0, lo_thr_q, 1'b0, hi_thr_q};
   end

   // combinational read data, valid in the access phase
   always @*
   begin
      prdata = rd_acc ? rdata_d : 32'h00000000;
   end
endmodule // cfs_regs
